// ===== pia_regs.sv
// Identification low and auto-negotiation advertisement registers.
`timescale 1ns/10ps
`include "pia_regs_map.svh"

module pia_regs
  import pia_pkg::*;
#(
  // Arbitrary identity defaults; replace with the assigned values.
  parameter logic [5:0] OUI_LOW_DEF = 6'h15,
  parameter logic [5:0] MODEL_DEF   = 6'h2a,
  parameter logic [3:0] REV_DEF     = 4'h5
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Management register port
  input  wire logic [4:0]  reg_index,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata_ff,
  output logic             reg_rvalid_ff,
  // Loader write port
  input  wire logic        loader_wr,
  input  wire logic [15:0] loader_data,
  // Strap pins of this port
  input  wire logic        autoneg_pin,
  input  wire logic        speed_pin,
  input  wire logic        duplex_pin,
  input  wire logic        manual_flow_ctl_pin_cfg,
  input  wire logic        full_duplex_pause_pin_cfg,
  // Values toward the negotiation engine
  output logic      [15:0] advertise_ff,
  output logic      [15:0] ident_low_ff,
  output logic             straps_done_ff
);

  // ---------------------------------------------------------------
  // Default advertisement computed from a strap set
  // ---------------------------------------------------------------
  function automatic logic [15:0] adv_default(input pia_strap_s st);
    logic [15:0] v;
    v = `PIA_ADV_RESET;
    v[`PIA_ADV_SYM_PAUSE]  = ~st.manual_flow_ctl_pin_cfg;
    v[`PIA_ADV_ASYM_PAUSE] = ~st.manual_flow_ctl_pin_cfg &
                             st.full_duplex_pause_pin_cfg;
    v[`PIA_ADV_10_FD] = st.autoneg | (~st.speed & st.duplex);
    v[`PIA_ADV_10_HD] = st.autoneg | ~st.speed;
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Strap synchronisation and capture
  // ---------------------------------------------------------------
  pia_strap_s strap_lvl;
  pia_strap_s strap_cap_ff;
  pia_cap_e   cap_ff;
  logic [1:0] settle_ff;

  pia_strap_sync #(
    .WIDTH (5)
  ) pia_strap_sync_i (
    .clock    (clock),
    .rst      (rst),
    .pin_in   ({autoneg_pin, speed_pin, duplex_pin,
                manual_flow_ctl_pin_cfg, full_duplex_pause_pin_cfg}),
    .level_ff (strap_lvl)
  );

  // Wait for the synchroniser to fill before sampling, so the captured
  // set is the level at release and not the cleared pipeline.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cap_ff    <= PIA_WAIT;
      settle_ff <= 2'd0;
    end else begin
      case (cap_ff)
        PIA_WAIT: begin
          settle_ff <= settle_ff + 2'd1;
          if (settle_ff == `PIA_STRAP_SETTLE) begin
            cap_ff <= PIA_LOAD;
          end
        end
        PIA_LOAD: begin
          cap_ff <= PIA_DONE;
        end
        PIA_DONE: begin
          cap_ff <= PIA_DONE;
        end
        default: begin
          cap_ff <= PIA_WAIT;
        end
      endcase
    end
  end

  // The strap set is held once; later pin changes have no effect.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strap_cap_ff   <= '0;
      straps_done_ff <= 1'b0;
    end else if (cap_ff == PIA_LOAD) begin
      strap_cap_ff   <= strap_lvl;
      straps_done_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  logic wr_ident;
  logic wr_adv;
  assign wr_ident = reg_wr && (reg_index == `PIA_IDX_IDENT_LOW);
  assign wr_adv   = reg_wr && (reg_index == `PIA_IDX_ADVERTISE);

  // Identification low: all three fields are software writable.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ident_low_ff <= {OUI_LOW_DEF, MODEL_DEF, REV_DEF};
    end else if (wr_ident) begin
      ident_low_ff[`PIA_ID_OUI_HI:`PIA_ID_OUI_LO] <=
        reg_wdata[`PIA_ID_OUI_HI:`PIA_ID_OUI_LO];
      ident_low_ff[`PIA_ID_MODEL_HI:`PIA_ID_MODEL_LO] <=
        reg_wdata[`PIA_ID_MODEL_HI:`PIA_ID_MODEL_LO];
      ident_low_ff[`PIA_ID_REV_HI:`PIA_ID_REV_LO] <=
        reg_wdata[`PIA_ID_REV_HI:`PIA_ID_REV_LO];
    end
  end

  // Advertisement: strap load, then loader, then software. The loader
  // outranks software so a reload is never half overwritten.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      advertise_ff <= `PIA_ADV_RESET;
    end else if (cap_ff == PIA_LOAD) begin
      advertise_ff <= adv_default(strap_lvl);
    end else if (loader_wr) begin
      advertise_ff <= loader_data & `PIA_ADV_WR_MASK;
    end else if (wr_adv) begin
      // Bit 12 is stored as written; keeping it zero is up to software.
      advertise_ff <= reg_wdata & `PIA_ADV_WR_MASK;
    end
  end

  // ---------------------------------------------------------------
  // Register reads; unmapped indices return zero.
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata_ff  <= 16'h0000;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_rd;
      if (!reg_rd) begin
        reg_rdata_ff <= 16'h0000;
      end else if (reg_index == `PIA_IDX_IDENT_LOW) begin
        reg_rdata_ff <= ident_low_ff;
      end else if (reg_index == `PIA_IDX_ADVERTISE) begin
        reg_rdata_ff <= advertise_ff;
      end else begin
        reg_rdata_ff <= 16'h0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sym_pause_def_a: assert property (
    cap_ff == PIA_LOAD && !strap_lvl.manual_flow_ctl_pin_cfg |=>
    advertise_ff[`PIA_ADV_SYM_PAUSE] &&
    advertise_ff[`PIA_ADV_ASYM_PAUSE] ==
      $past(strap_lvl.full_duplex_pause_pin_cfg))
    else $error("pause default wrong with manual strap low");

  manual_pause_a: assert property (
    cap_ff == PIA_LOAD && strap_lvl.manual_flow_ctl_pin_cfg |=>
    advertise_ff[11:10] == 2'b00)
    else $error("pause bits not cleared with manual strap high");

  ten_full_def_a: assert property (
    cap_ff == PIA_LOAD |=> advertise_ff[`PIA_ADV_10_FD] ==
    ($past(strap_lvl.autoneg) |
     (~$past(strap_lvl.speed) & $past(strap_lvl.duplex))))
    else $error("10BASE-T full default wrong");

  ten_half_def_a: assert property (
    cap_ff == PIA_LOAD |=> advertise_ff[`PIA_ADV_10_HD] ==
    ($past(strap_lvl.autoneg) | ~$past(strap_lvl.speed)))
    else $error("10BASE-T half default wrong");

  strap_capture_a: assert property (
    $rose(straps_done_ff) |-> $past(cap_ff) == PIA_LOAD &&
    strap_cap_ff == $past(strap_lvl) ##1 straps_done_ff [*4])
    else $error("strap capture not held after release");

  loader_write_a: assert property (
    loader_wr && cap_ff != PIA_LOAD |=>
    advertise_ff == ($past(loader_data) & `PIA_ADV_WR_MASK))
    else $error("loader write not taken");

  ro_bits_zero_a: assert property (
    advertise_ff[15:14] == 2'b00 && !advertise_ff[9])
    else $error("read-only advertisement bits not zero");

  ident_write_a: assert property (
    wr_ident |=> ident_low_ff == $past(reg_wdata))
    else $error("identification write not stored");

  read_path_a: assert property (
    reg_rd && reg_index == `PIA_IDX_ADVERTISE |=>
    reg_rvalid_ff && reg_rdata_ff == $past(advertise_ff))
    else $error("advertisement read returned wrong value");

  sw_adv_write_a: assert property (
    wr_adv && !loader_wr && cap_ff != PIA_LOAD |=>
    advertise_ff[`PIA_ADV_RFAULT] == $past(reg_wdata[13]))
    else $error("remote fault bit write not stored");

  capture_seen_c: cover property ($rose(straps_done_ff));
  loader_seen_c:  cover property (straps_done_ff && loader_wr);
  adv_read_c:     cover property (reg_rvalid_ff && reg_rdata_ff[10]);

endmodule

// ===== pia_regs_map.svh
// Register indices, field positions, reset values and timing counts.
`ifndef PIA_REGS_MAP_SVH
`define PIA_REGS_MAP_SVH

// -----------------------------------------------------------------
// Register indices
// -----------------------------------------------------------------
`define PIA_IDX_IDENT_LOW   5'h03
`define PIA_IDX_ADVERTISE   5'h04

// -----------------------------------------------------------------
// Identification low fields
// -----------------------------------------------------------------
`define PIA_ID_OUI_HI       15
`define PIA_ID_OUI_LO       10
`define PIA_ID_MODEL_HI     9
`define PIA_ID_MODEL_LO     4
`define PIA_ID_REV_HI       3
`define PIA_ID_REV_LO       0

// -----------------------------------------------------------------
// Advertisement fields
// -----------------------------------------------------------------
`define PIA_ADV_RFAULT      13
`define PIA_ADV_RSVD12      12
`define PIA_ADV_ASYM_PAUSE  11
`define PIA_ADV_SYM_PAUSE   10
`define PIA_ADV_100_FD      8
`define PIA_ADV_100_HD      7
`define PIA_ADV_10_FD       6
`define PIA_ADV_10_HD       5
`define PIA_ADV_SEL_HI      4
`define PIA_ADV_SEL_LO      0

// Writable bits; 15:14 and 9 are read-only zero.
`define PIA_ADV_WR_MASK     16'h3dff
// Constant reset value before the straps are captured.
`define PIA_ADV_RESET       16'h0181
`define PIA_ADV_SEL_ETH     5'h01

// -----------------------------------------------------------------
// Timing: cycles from reset release until the straps are settled.
// -----------------------------------------------------------------
`define PIA_STRAP_SETTLE    2'd3

`endif

// ===== pia_pkg.sv
// Types shared by the identification and advertisement register block.
package pia_pkg;

  // Strap set of one port, as filtered by the strap synchroniser.
  typedef struct packed {
    logic autoneg;
    logic speed;
    logic duplex;
    logic manual_flow_ctl_pin_cfg;
    logic full_duplex_pause_pin_cfg;
  } pia_strap_s;

  // Strap capture sequence after reset release.
  typedef enum logic [2:0] {
    PIA_WAIT = 3'b001,
    PIA_LOAD = 3'b010,
    PIA_DONE = 3'b100
  } pia_cap_e;

endpackage

// ===== pia_strap_sync.sv
// Three-stage synchroniser with agreement filter for strap pins.
`timescale 1ns/10ps

module pia_strap_sync
  import pia_pkg::*;
#(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Asynchronous pin levels and their filtered copy
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_ff
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;

  // The first stage is only read by the second, to contain metastability.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A bit changes only once the second and third stage agree.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      level_ff <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          level_ff[i] <= s3_ff[i];
        end
      end
    end
  end

endmodule

// ===== pia_far_model.sv
// Far-side model: strap pins and the configuration loader.
`timescale 1ns/10ps

module pia_far_model (
  // Clock
  input  wire logic        clock,
  // Requested strap set and loader word
  input  wire logic [4:0]  strap_req,
  input  wire logic        ld_go,
  input  wire logic [15:0] ld_word,
  // Pins toward the block
  output logic      [4:0]  strap_pins,
  output logic             loader_wr,
  output logic      [15:0] loader_data
);
  // Straps are static levels, one private set for this port.
  assign strap_pins = strap_req;

  // The loader sends one whole word per request.
  // Outside a pulse the data is inverted each cycle, so stale data matches only every other cycle.
  // The request is sampled on the edge itself, so it cannot race the
  // bench, which changes its requests one step after the same edge.
  logic        go_now;
  logic [15:0] word_now;

  initial begin
    loader_wr   = 1'b0;
    loader_data = 16'h5a5a;
  end
  always @(posedge clock) begin
    go_now   = ld_go;
    word_now = ld_word;
    #1;
    loader_wr   = go_now;
    loader_data = go_now ? word_now : ~loader_data;
  end
endmodule

// ===== pia_regs_tb.sv
// Self-checking bench for the identification and advertisement registers.
`timescale 1ns/10ps

module pia_regs_tb;
  import pia_pkg::*;
  // Arbitrary identity values, chosen only to differ from the defaults.
  localparam logic [5:0] OUI_T   = 6'h3c;
  localparam logic [5:0] MODEL_T = 6'h11;
  localparam logic [3:0] REV_T   = 4'h9;
  localparam logic [15:0] ID_T   = {OUI_T, MODEL_T, REV_T};

  logic        clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        ld_go = 1'b0, loader_wr, reg_rvalid_ff, straps_done_ff;
  logic [4:0]  reg_index = 5'h00, strap_req = 5'h00, sp;
  logic [15:0] reg_wdata = 16'h0000, ld_word = 16'h0000, w, loader_data;
  logic [15:0] reg_rdata_ff, advertise_ff, ident_low_ff;
  logic [15:0] exp_q[$];
  int          bad_count = 0, checks_done = 0, cycles = 0, seed = 32'hea33;

  always #2 clock = ~clock;

  pia_far_model pia_far_model_i (.clock(clock), .strap_req(strap_req),
    .ld_go(ld_go), .ld_word(ld_word), .strap_pins(sp),
    .loader_wr(loader_wr), .loader_data(loader_data));

  pia_regs #(.OUI_LOW_DEF(OUI_T), .MODEL_DEF(MODEL_T), .REV_DEF(REV_T))
  pia_regs_i (.clock(clock), .rst(rst), .reg_index(reg_index),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
    .loader_wr(loader_wr), .loader_data(loader_data),
    .autoneg_pin(sp[4]), .speed_pin(sp[3]), .duplex_pin(sp[2]),
    .manual_flow_ctl_pin_cfg(sp[1]), .full_duplex_pause_pin_cfg(sp[0]),
    .advertise_ff(advertise_ff), .ident_low_ff(ident_low_ff),
    .straps_done_ff(straps_done_ff));

  // -------------------------------------------------------------
  // Comparison, scoreboard and closing
  // -------------------------------------------------------------
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Read data is sampled mid-cycle, where it has long settled.
  always @(negedge clock) begin
    if (reg_rvalid_ff === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("[ERR] read_valid expected 0 seen 1");
      end else
        check("read_data", reg_rdata_ff, exp_q.pop_front());
    end
  end

  // A hang ends the run; the limit is far above the planned length.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      wrap_up();
    end
  end

  // -------------------------------------------------------------
  // Drivers
  // -------------------------------------------------------------
  task automatic wr(logic [4:0] idx, logic [15:0] d);
    @(posedge clock);
    #1 reg_index = idx;
    reg_wr = 1'b1;
    reg_wdata = d;
    @(posedge clock);
    #1 reg_wr = 1'b0;
  endtask

  task automatic rd(logic [4:0] idx, logic [15:0] exp);
    @(posedge clock);
    #1 reg_index = idx;
    reg_rd = 1'b1;
    exp_q.push_back(exp);
    @(posedge clock);
    #1 reg_rd = 1'b0;
  endtask

  task automatic ld(logic [15:0] d);
    @(posedge clock);
    #1 ld_go = 1'b1;
    ld_word = d;
    @(posedge clock);
    #1 ld_go = 1'b0;
  endtask

  // Straps are set while reset is held and stay put afterwards. A
  // mid-run reset waits one edge, so the last read is checked first.
  task automatic boot(logic [4:0] s);
    int n;
    n = 0;
    if (rst === 1'b0) begin
      @(posedge clock);
      #1 rst = 1'b1;
    end
    strap_req = s;
    repeat (8) @(posedge clock);
    #1 rst = 1'b0;
    while (straps_done_ff !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    check("straps_done", {15'h0000, straps_done_ff}, 16'h0001);
    check("advertise", advertise_ff, adv_def(s));
    check("ident_low", ident_low_ff, ID_T);
  endtask

  function automatic logic [15:0] adv_def(logic [4:0] s);
    logic [15:0] a;
    a = 16'h0181;
    a[11] = s[1] ? 1'b0 : s[0];
    a[10] = ~s[1];
    a[6] = s[4] | (~s[3] & s[2]);
    a[5] = s[4] | ~s[3];
    return a;
  endfunction

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    for (int i = 0; i < 32; i++) begin
      boot(i[4:0]);
      rd(5'h04, adv_def(i[4:0]));
    end
    $display("test strap defaults done");
    rd(5'h03, ID_T);
    w = 16'($random(seed));
    wr(5'h03, w);
    rd(5'h03, w);
    wr(5'h00, 16'hffff);
    rd(5'h03, w);
    rd(5'h05, 16'h0000);
    $display("test ident done");
    // Software keeps the reserved bit 12 at zero.
    w = 16'($random(seed)) & 16'hefff;
    wr(5'h04, w);
    rd(5'h04, w & 16'h3dff);
    wr(5'h04, 16'hefff);
    rd(5'h04, 16'h2dff);
    $display("test advertise write done");
    w = 16'($random(seed));
    ld(w);
    rd(5'h04, w & 16'h3dff);
    // The loader beats a software write landing on the same edge.
    w = 16'($random(seed));
    fork
      ld(w);
      begin
        @(posedge clock);
        wr(5'h04, 16'h0000);
      end
    join
    rd(5'h04, w & 16'h3dff);
    $display("test loader done");
    w = 16'($random(seed));
    boot(w[4:0]);
    rd(5'h03, ID_T);
    rd(5'h04, adv_def(w[4:0]));
    repeat (3) @(posedge clock);
    $display("test second reset done");
    wrap_up();
  end
endmodule
